// ===== hw/conv_ctl_pkg.sv
// Constants, register map and field layout of the converter control block.
// Assumes a single 20 MHz clock and a simple strobe register port.
// Operation
// - Each group picks one of seven trigger events, or code 111 its software start.
// - Conversions start on a rising edge of the chosen trigger, never its level.
// - With DMA enabled, every stored regular result raises a DMA request.
// - Sensor-reference enable turns on channels 16, 17; clearing powers sensor down.
// - Battery enable turns on channel 18 and its divide-by-two bridge.
// - Converter-on rewrite or trigger starts the configured sequence, sensor included.
// - Interrupt on regular/inserted end or watchdog, each with own enable.
// - Two-bit resolution field selects 12, 10, 8 or 6 result bits.
// - Conversion takes 12.5/10.5/8.5/6.5 clocks after sampling; totals 14/12/10/8.
// - Oversampling accumulates N conversions, N from 2 to 256 by powers of two.
// - The oversampled sum shifts right by 0 to 8 bits.
// - Twenty-bit accumulator; shifted result rounded, low 16 bits stored.
// - Bits above 16 after shifting are dropped without saturation.
// - Same sample time throughout; one result every N conversions.
// - Oversampling works with both groups, all triggers and all modes.
// - Status bits 31:5 are reserved and read as zero.
// - End-of-conversion flag set by hardware, cleared by writing 0 or result read.
package conv_ctl_pkg;
  // ****************
  // Register map
  // ****************
  localparam logic [7:0] STATUS_ADDR      = 8'h00;
  localparam logic [7:0] CTRL_ZERO_ADDR   = 8'h04;
  localparam logic [7:0] CTRL_ONE_ADDR    = 8'h08;
  localparam logic [7:0] OVS_CTRL_ADDR    = 8'h0c;
  localparam logic [7:0] REG_RESULT_ADDR  = 8'h10;
  localparam logic [7:0] INS_RESULT_ADDR  = 8'h14;
  localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;

  // Status bits
  localparam int ST_WATCHDOG   = 0;
  localparam int ST_END_CONV   = 1;
  localparam int ST_END_INS    = 2;
  localparam int ST_START_INS  = 3;
  localparam int ST_START_REG  = 4;
  localparam int ST_WIDTH      = 5;

  // Control zero: interrupt enables and resolution
  localparam int C0_END_CONV_IE = 5;
  localparam int C0_WATCHDOG_IE = 6;
  localparam int C0_END_INS_IE  = 7;
  localparam int C0_RES_LO      = 24;

  // Control one
  localparam int C1_CONV_ON     = 0;
  localparam int C1_DMA         = 8;
  localparam int C1_INS_SEL_LO  = 12;
  localparam int C1_INS_EXT_EN  = 15;
  localparam int C1_REG_SEL_LO  = 17;
  localparam int C1_REG_EXT_EN  = 20;
  localparam int C1_INS_SW      = 21;
  localparam int C1_REG_SW      = 22;
  localparam int C1_SENSOR_EN   = 23;
  localparam int C1_BATTERY_EN  = 24;

  // Oversample control
  localparam int OV_ENABLE      = 0;
  localparam int OV_RATIO_LO    = 2;
  localparam int OV_SHIFT_LO    = 5;

  localparam logic [2:0] TRIG_SOFTWARE = 3'h7;
  localparam int TRIG_EVENTS  = 7;
  localparam int ACC_WIDTH    = 20;
  localparam int DATA_WIDTH   = 16;
  localparam int SAMPLE_BITS  = 12;
  localparam logic [3:0] SHIFT_MAX = 4'h8;

  // Conversion timing in clocks: sample 1.5 plus convert, whole cycles
  localparam logic [3:0] TOTAL_12 = 4'he;
  localparam logic [3:0] TOTAL_10 = 4'hc;
  localparam logic [3:0] TOTAL_8  = 4'ha;
  localparam logic [3:0] TOTAL_6  = 4'h8;

  typedef enum logic [1:0] {RES_12, RES_10, RES_8, RES_6} resolution_t;
endpackage

// ===== hw/oversample_unit.sv
// Oversampling accumulator with shift, rounding and 16-bit truncation.
// Assumes one sample_valid pulse per finished conversion, same clock.
module oversample_unit
  import conv_ctl_pkg::*;
(
  input  wire logic                   clk,          // Clock
  input  wire logic                   rst,          // Async reset
  input  wire logic                   enable,       // Oversampling on
  input  wire logic [2:0]             ratio,        // N = 2 << ratio
  input  wire logic [3:0]             shift,        // Right shift 0..8
  input  wire logic                   sample_valid, // Conversion done
  input  wire logic [SAMPLE_BITS-1:0] sample,       // Raw result
  output logic                        out_valid,    // Result pulse
  output logic [DATA_WIDTH-1:0]       out_data      // Result
);
  logic [ACC_WIDTH-1:0] acc_reg;
  logic [8:0]           count_reg;
  logic [ACC_WIDTH-1:0] sum;
  logic [ACC_WIDTH:0]   rounded;
  logic [8:0]           target;
  logic [3:0]           sh;

  always_comb begin
    sum     = acc_reg + ACC_WIDTH'(sample);
    sh      = (shift > SHIFT_MAX) ? SHIFT_MAX : shift;
    rounded = (sh == 4'h0) ? {1'b0, sum}
            : ({1'b0, sum} + ((ACC_WIDTH + 1)'(1) << (sh - 4'h1))) >> sh;
    target  = 9'(9'h2 << ratio);
  end

  // ****************
  // Accumulate
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg   <= '0;
      count_reg <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= 1'b0;
      if (!enable) begin
        acc_reg   <= '0;
        count_reg <= '0;
        if (sample_valid) begin
          out_valid <= 1'b1;
          out_data  <= DATA_WIDTH'(sample);
        end
      end else if (sample_valid) begin
        if (count_reg + 9'h1 == target) begin
          out_valid <= 1'b1;
          out_data  <= rounded[DATA_WIDTH-1:0];
          acc_reg   <= '0;
          count_reg <= '0;
        end else begin
          acc_reg   <= sum;
          count_reg <= count_reg + 9'h1;
        end
      end
    end
  end
endmodule

// ===== hw/conv_ctl.sv
// Converter control: triggers, timing, oversampling, flags, DMA, interrupts.
// Assumes the analog core returns a result when conv_done pulses; same clock.
//
// Implementation choice: the strobed register port.
module conv_ctl
  import conv_ctl_pkg::*;
(
  input  wire logic                   clk,             // 20 MHz clock
  input  wire logic                   rst,             // Async reset
  input  wire logic [7:0]             addr,            // Register address
  input  wire logic [31:0]            wdata,           // Write data
  input  wire logic                   wr,              // Write strobe
  input  wire logic                   rd,              // Read strobe
  output logic      [31:0]            rdata,           // Read data
  input  wire logic [6:0]             regular_events,  // Regular trigger pins
  input  wire logic [6:0]             inserted_events, // Inserted trigger pins
  input  wire logic [SAMPLE_BITS-1:0] analog_result,   // Raw core result
  input  wire logic                   watchdog_hit,    // Watchdog compare event
  output logic                        sample_start,    // Core starts sampling
  output logic                        conv_done,       // Core result valid
  output logic [1:0]                  resolution_out,  // Core resolution
  output logic                        temperature_on,  // Sensor powered
  output logic                        reference_on,    // Reference channel on
  output logic                        battery_on,      // Battery bridge on
  output logic                        dma_request,     // DMA request pulse
  output logic                        irq              // Interrupt level
);
  logic [ST_WIDTH-1:0] status_reg;
  logic [31:0]         ctrl_zero_reg;
  logic [31:0]         ctrl_one_reg;
  logic [31:0]         ovs_ctrl_reg;
  logic [15:0]         reg_result_reg;
  logic [15:0]         ins_result_reg;
  logic [6:0]          reg_sync1_reg;
  logic [6:0]          reg_sync2_reg;
  logic [6:0]          reg_prev_reg;
  logic [6:0]          ins_sync1_reg;
  logic [6:0]          ins_sync2_reg;
  logic [6:0]          ins_prev_reg;
  logic [1:0]          wd_sync_reg;
  logic                wd_prev_reg;
  logic [3:0]          cycle_reg;
  logic                busy_reg;
  logic                inserted_reg;
  logic [SAMPLE_BITS-1:0] raw_sample;

  typedef enum logic [1:0] {IDLE, CONVERT} phase_t;
  phase_t phase_reg;

  // ****************
  // Decode
  // ****************
  logic       wr_status, wr_one, rd_result, on_rewrite;
  logic [2:0] reg_sel, ins_sel;
  logic       reg_edge, ins_edge, wd_edge;
  logic       reg_trig, ins_trig, start;
  logic       ovs_valid;
  logic [15:0] ovs_data;
  logic [3:0] total;

  always_comb begin
    wr_status  = wr && (addr == STATUS_ADDR);
    wr_one     = wr && (addr == CTRL_ONE_ADDR);
    rd_result  = rd && (addr == REG_RESULT_ADDR);
    reg_sel    = ctrl_one_reg[C1_REG_SEL_LO +: 3];
    ins_sel    = ctrl_one_reg[C1_INS_SEL_LO +: 3];
    // Converter-on rewritten while already on starts a regular sequence
    on_rewrite = wr_one && ctrl_one_reg[C1_CONV_ON] && wdata[C1_CONV_ON]
               && (wdata[31:1] == ctrl_one_reg[31:1]);
    reg_edge = 1'b0;
    ins_edge = 1'b0;
    if (reg_sel != TRIG_SOFTWARE)
      reg_edge = reg_sync2_reg[reg_sel] && !reg_prev_reg[reg_sel];
    if (ins_sel != TRIG_SOFTWARE)
      ins_edge = ins_sync2_reg[ins_sel] && !ins_prev_reg[ins_sel];
    wd_edge  = wd_sync_reg[1] && !wd_prev_reg;
    reg_trig = ctrl_one_reg[C1_CONV_ON] && (on_rewrite
             || (reg_sel == TRIG_SOFTWARE && ctrl_one_reg[C1_REG_SW])
             || (ctrl_one_reg[C1_REG_EXT_EN] && reg_edge));
    ins_trig = ctrl_one_reg[C1_CONV_ON] && (
               (ins_sel == TRIG_SOFTWARE && ctrl_one_reg[C1_INS_SW])
             || (ctrl_one_reg[C1_INS_EXT_EN] && ins_edge));
    start    = !busy_reg && (reg_trig || ins_trig);
    case (resolution_t'(ctrl_zero_reg[C0_RES_LO +: 2]))
      RES_12:  total = TOTAL_12;
      RES_10:  total = TOTAL_10;
      RES_8:   total = TOTAL_8;
      RES_6:   total = TOTAL_6;
      default: total = TOTAL_12;
    endcase
  end

  // ****************
  // Pin synchronisers
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_sync1_reg <= '0;
      reg_sync2_reg <= '0;
      reg_prev_reg  <= '0;
      ins_sync1_reg <= '0;
      ins_sync2_reg <= '0;
      ins_prev_reg  <= '0;
      wd_sync_reg   <= '0;
      wd_prev_reg   <= 1'b0;
    end else begin
      reg_sync1_reg <= regular_events;
      reg_sync2_reg <= reg_sync1_reg;
      reg_prev_reg  <= reg_sync2_reg;
      ins_sync1_reg <= inserted_events;
      ins_sync2_reg <= ins_sync1_reg;
      ins_prev_reg  <= ins_sync2_reg;
      wd_sync_reg   <= {wd_sync_reg[0], watchdog_hit};
      wd_prev_reg   <= wd_sync_reg[1];
    end
  end

  // ****************
  // Conversion timing
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg    <= IDLE;
      cycle_reg    <= '0;
      inserted_reg <= 1'b0;
      sample_start <= 1'b0;
      conv_done    <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      sample_start <= 1'b0;
      conv_done    <= 1'b0;
      case (phase_reg)
        IDLE: begin
          if (start) begin
            phase_reg    <= CONVERT;
            inserted_reg <= ins_trig; // Inserted wins a tie
            cycle_reg    <= total;
            sample_start <= 1'b1;
            busy_reg     <= 1'b1;
          end
        end
        CONVERT: begin
          if (cycle_reg == 4'h1) begin
            phase_reg <= IDLE;
            conv_done <= 1'b1;
            busy_reg  <= 1'b0;
          end
          cycle_reg <= cycle_reg - 4'h1;
        end
        default: phase_reg <= IDLE;
      endcase
    end
  end

  always_comb raw_sample = analog_result;

  oversample_unit u_ovs (
    .clk          (clk),
    .rst          (rst),
    .enable       (ovs_ctrl_reg[OV_ENABLE]),
    .ratio        (ovs_ctrl_reg[OV_RATIO_LO +: 3]),
    .shift        (ovs_ctrl_reg[OV_SHIFT_LO +: 4]),
    .sample_valid (conv_done),
    .sample       (raw_sample),
    .out_valid    (ovs_valid),
    .out_data     (ovs_data)
  );

  // ****************
  // Registers
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_zero_reg <= '0;
      ovs_ctrl_reg  <= '0;
    end else if (wr) begin
      if (addr == CTRL_ZERO_ADDR)
        ctrl_zero_reg <= wdata;
      if (addr == OVS_CTRL_ADDR && !ctrl_one_reg[C1_CONV_ON])
        ovs_ctrl_reg <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_one_reg <= '0;
    end else begin
      if (wr_one)
        ctrl_one_reg <= wdata;
      // Software starts clear once the conversion launches
      if (start && !ins_trig)
        ctrl_one_reg[C1_REG_SW] <= 1'b0;
      if (start && ins_trig)
        ctrl_one_reg[C1_INS_SW] <= 1'b0;
    end
  end

  // Status: hardware set beats software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= STATUS_RESET[ST_WIDTH-1:0];
    end else begin
      logic [ST_WIDTH-1:0] set_bits;
      logic [ST_WIDTH-1:0] next;
      set_bits = '0;
      set_bits[ST_START_REG] = start && !ins_trig;
      set_bits[ST_START_INS] = start && ins_trig;
      set_bits[ST_END_CONV]  = ovs_valid;
      set_bits[ST_END_INS]   = ovs_valid && inserted_reg;
      set_bits[ST_WATCHDOG]  = wd_edge;
      next = status_reg;
      if (wr_status)
        next = status_reg & wdata[ST_WIDTH-1:0];
      if (rd_result)
        next[ST_END_CONV] = 1'b0;
      status_reg <= next | set_bits;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_result_reg <= '0;
      ins_result_reg <= '0;
      dma_request    <= 1'b0;
    end else begin
      dma_request <= 1'b0;
      if (ovs_valid && !inserted_reg) begin
        reg_result_reg <= ovs_data;
        dma_request    <= ctrl_one_reg[C1_DMA];
      end
      if (ovs_valid && inserted_reg)
        ins_result_reg <= ovs_data;
    end
  end

  // ****************
  // Outputs and read
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resolution_out <= '0;
      temperature_on <= 1'b0;
      reference_on   <= 1'b0;
      battery_on     <= 1'b0;
      irq            <= 1'b0;
    end else begin
      resolution_out <= ctrl_zero_reg[C0_RES_LO +: 2];
      temperature_on <= ctrl_one_reg[C1_SENSOR_EN];
      reference_on   <= ctrl_one_reg[C1_SENSOR_EN];
      battery_on     <= ctrl_one_reg[C1_BATTERY_EN];
      irq <= (status_reg[ST_END_CONV] && ctrl_zero_reg[C0_END_CONV_IE])
          || (status_reg[ST_END_INS]  && ctrl_zero_reg[C0_END_INS_IE])
          || (status_reg[ST_WATCHDOG] && ctrl_zero_reg[C0_WATCHDOG_IE]);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (rd) begin
        case (addr)
          STATUS_ADDR:     rdata <= {27'h0, status_reg};
          CTRL_ZERO_ADDR:  rdata <= ctrl_zero_reg;
          CTRL_ONE_ADDR:   rdata <= ctrl_one_reg;
          OVS_CTRL_ADDR:   rdata <= ovs_ctrl_reg;
          REG_RESULT_ADDR: rdata <= {16'h0, reg_result_reg};
          INS_RESULT_ADDR: rdata <= {16'h0, ins_result_reg};
          default:         rdata <= '0;
        endcase
      end
    end
  end
endmodule

// ===== tb/core_model.sv
// Behavioural analog core beside the converter control block.
// Assumes the result is taken only in the cycle that conv_done is high.
module core_model
  import conv_ctl_pkg::*;
(
  input  wire logic [SAMPLE_BITS-1:0] value,         // Result to return
  input  wire logic                   conv_done,     // Result taken
  output logic      [SAMPLE_BITS-1:0] analog_result  // Core result bus
);
  timeunit 1ns;
  timeprecision 1ns;
  // Inverted outside the result cycle so stale data never matches
  assign analog_result = conv_done ? value : ~value;
endmodule

// ===== tb/conv_ctl_chk.sv
// Concurrent checks on the converter control ports.
// Assumes it is bound into conv_ctl; one clock, async active-high reset.
module conv_ctl_chk
  import conv_ctl_pkg::*;
(
  input wire logic        clk,            // Clock
  input wire logic        rst,            // Reset
  input wire logic [7:0]  addr,           // Address
  input wire logic [31:0] wdata,          // Write data
  input wire logic        wr,             // Write strobe
  input wire logic        rd,             // Read strobe
  input wire logic [31:0] rdata,          // Read data
  input wire logic        sample_start,   // Launch
  input wire logic        conv_done,      // Result valid
  input wire logic [1:0]  resolution_out, // Resolution
  input wire logic        temperature_on, // Sensor on
  input wire logic        reference_on,   // Reference on
  input wire logic        battery_on,     // Bridge on
  input wire logic        dma_request     // DMA request
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  cyc_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ********
  // Helpers
  // ********
  // Cycles since launch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cyc_reg <= 4'h0;
    else if (sample_start) cyc_reg <= 4'h1;
    else if (conv_done) cyc_reg <= 4'h0;
    else if (cyc_reg != 4'h0) cyc_reg <= cyc_reg + 4'h1;
  end
  sequence s_quiet;
    !sample_start [*7];
  endsequence
  sequence s_ctrl_one_wr;
    wr && addr == CTRL_ONE_ADDR;
  endsequence
  property p_reserved;
    $past(rd) && $past(addr) == STATUS_ADDR |-> rdata[31:ST_WIDTH] == 27'h0;
  endproperty
  property p_conv_time;
    conv_done |-> cyc_reg == TOTAL_12 - {1'b0, resolution_out, 1'b0};
  endproperty
  property p_start_gap;
    sample_start |=> s_quiet;
  endproperty
  property p_dma_pulse;
    dma_request |=> !dma_request;
  endproperty
  property p_sensor_pair;
    temperature_on == reference_on;
  endproperty
  property p_sensor_wr;
    s_ctrl_one_wr |=> ##1 temperature_on == $past(wdata[C1_SENSOR_EN], 2);
  endproperty
  property p_battery_wr;
    s_ctrl_one_wr |=> ##1 battery_on == $past(wdata[C1_BATTERY_EN], 2);
  endproperty
  property p_res_wr;
    wr && addr == CTRL_ZERO_ADDR |=> ##1 resolution_out == $past(wdata[C0_RES_LO +: 2], 2);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
  a_conv_time: assert property (p_conv_time) else $error("bad conversion time");
  a_start_gap: assert property (p_start_gap) else $error("launch too soon");
  a_dma_pulse: assert property (p_dma_pulse) else $error("long dma request");
  a_sensor_pair: assert property (p_sensor_pair) else $error("sensor pair split");
  a_sensor_wr: assert property (p_sensor_wr) else $error("sensor enable wrong");
  a_battery_wr: assert property (p_battery_wr) else $error("battery enable wrong");
  a_res_wr: assert property (p_res_wr) else $error("resolution wrong");
endmodule

// ===== tb/adc_trigger_resolution_oversampler_test.sv
// Self-checking bench for conv_ctl: registers, triggers, timing, oversampling.
// Assumes conv_ctl_pkg, conv_ctl, conv_ctl_chk and core_model compile first.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module adc_trigger_resolution_oversampler_test import conv_ctl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, watchdog_hit = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [6:0]  regular_events = 7'h00, inserted_events = 7'h00;
  logic [11:0] core_value = 12'h000, analog_result;
  logic [1:0]  resolution_out;
  logic        sample_start, conv_done, temperature_on, reference_on, battery_on;
  logic        dma_request, irq;
  int          fail_count, n_tests, cycles, dma_n, n, m;
  conv_ctl DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .regular_events(regular_events), .inserted_events(inserted_events),
    .analog_result(analog_result), .watchdog_hit(watchdog_hit), .sample_start(sample_start),
    .conv_done(conv_done), .resolution_out(resolution_out), .temperature_on(temperature_on),
    .reference_on(reference_on), .battery_on(battery_on), .dma_request(dma_request), .irq(irq));
  core_model core (.value(core_value), .conv_done(conv_done), .analog_result(analog_result));
  // ********
  // Helpers
  // ********
  task automatic final_report;
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always #25 clk = ~clk;
  always @(negedge clk) begin
    cycles++;
    if (dma_request === 1'b1) dma_n++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic set_ev(input bit ins, input logic [6:0] v);
    @(posedge clk);
    if (ins) inserted_events <= v;
    else regular_events <= v;
  endtask
  // Cycles until launch (0), result (1) or DMA (2), capped at lim
  task automatic wait_on(input int w, input int lim, output int c);
    c = 0;
    do begin
      tick(1);
      c++;
    end while (c < lim && !((w == 0 && sample_start === 1'b1) ||
               (w == 1 && conv_done === 1'b1) || (w == 2 && dma_request === 1'b1)));
  endtask
  task automatic t_regs;
    rd_reg(STATUS_ADDR, d);
    `CHK(d, STATUS_RESET)
    wr_reg(STATUS_ADDR, 32'hffff_ffff);
    rd_reg(STATUS_ADDR, d);
    `CHK(d, STATUS_RESET)
    rd_reg(8'h20, d);
    `CHK(d, 32'h0)
    wr_reg(CTRL_ONE_ADDR, 32'h0180_0000);
    tick(1);
    `CHK({temperature_on, reference_on, battery_on}, 3'b111)
    wr_reg(CTRL_ONE_ADDR, 32'h0100_0000);
    tick(1);
    `CHK({temperature_on, reference_on, battery_on}, 3'b001)
  endtask
  task automatic t_soft;
    wr_reg(CTRL_ZERO_ADDR, 32'h0000_0020);
    wr_reg(CTRL_ONE_ADDR, 32'h0000_0001);
    core_value = 12'h5a3;
    wr_reg(CTRL_ONE_ADDR, 32'h004e_0101);
    wait_on(2, 40, n);
    `CHK(n < 40, 1'b1)
    tick(1);
    `CHK(irq, 1'b1)
    rd_reg(STATUS_ADDR, d);
    `CHK(d[ST_END_CONV], 1'b1)
    rd_reg(REG_RESULT_ADDR, d);
    `CHK(d, 32'h0000_05a3)
    rd_reg(STATUS_ADDR, d);
    `CHK(d[ST_END_CONV], 1'b0)
    `CHK(irq, 1'b0)
  endtask
  task automatic t_ext(input bit ins);
    logic [31:0] v;
    wr_reg(CTRL_ZERO_ADDR, ins ? 32'h0000_0080 : 32'h0000_0020);
    for (int k = 0; k < TRIG_EVENTS; k++) begin
      v = ins ? (32'h0000_8001 | (32'(k) << C1_INS_SEL_LO))
              : (32'h0010_0001 | (32'(k) << C1_REG_SEL_LO));
      wr_reg(CTRL_ONE_ADDR, v);
      wr_reg(STATUS_ADDR, 32'h0);
      m = dma_n;
      set_ev(ins, ~(7'h01 << k));
      wait_on(0, 20, n);
      `CHK(n, 20)
      set_ev(ins, 7'h7f);
      wait_on(0, 20, n);
      `CHK(n < 8, 1'b1)
      wait_on(1, 20, n);
      wait_on(0, 20, n);
      `CHK(n, 20)
      rd_reg(STATUS_ADDR, d);
      `CHK(d[ins ? ST_START_INS : ST_START_REG], 1'b1)
      `CHK(d[ST_END_INS], ins)
      `CHK(irq, 1'b1)
      `CHK(dma_n, m)
      set_ev(ins, 7'h00);
    end
  endtask
  task automatic t_wd;
    wr_reg(CTRL_ZERO_ADDR, 32'h0);
    wr_reg(STATUS_ADDR, 32'h0);
    @(posedge clk);
    watchdog_hit <= 1'b1;
    tick(6);
    `CHK(irq, 1'b0)
    rd_reg(STATUS_ADDR, d);
    `CHK(d[ST_WATCHDOG], 1'b1)
    wr_reg(CTRL_ZERO_ADDR, 32'h0000_0040);
    tick(2);
    `CHK(irq, 1'b1)
    wr_reg(STATUS_ADDR, 32'h0);
    tick(2);
    `CHK(irq, 1'b0)
    @(posedge clk);
    watchdog_hit <= 1'b0;
  endtask
  task automatic t_res;
    for (int r = 0; r < 4; r++) begin
      wr_reg(CTRL_ONE_ADDR, 32'h0);
      wr_reg(CTRL_ZERO_ADDR, 32'(r) << C0_RES_LO);
      wr_reg(CTRL_ONE_ADDR, 32'h1);
      `CHK(resolution_out, 2'(r))
      wr_reg(CTRL_ONE_ADDR, 32'h1);
      `CHK(sample_start, 1'b1)
      wait_on(1, 20, n);
      `CHK(n, int'(TOTAL_12) - 2 * r)
    end
    wr_reg(CTRL_ZERO_ADDR, 32'h0);
  endtask
  // Refused settings write while on; N rewrite starts give one result
  task automatic t_ovs(input int r, input int s, input logic [11:0] val,
                       input logic [15:0] res);
    wr_reg(CTRL_ONE_ADDR, 32'h0);
    wr_reg(OVS_CTRL_ADDR, 32'h1 | (32'(r) << OV_RATIO_LO) | (32'(s) << OV_SHIFT_LO));
    wr_reg(CTRL_ONE_ADDR, 32'h0000_0101);
    wr_reg(OVS_CTRL_ADDR, 32'h0);
    core_value = val;
    m = dma_n;
    repeat (2 << r) begin
      `CHK(dma_n, m)
      wr_reg(CTRL_ONE_ADDR, 32'h0000_0101);
      wait_on(1, 30, n);
    end
    wait_on(2, 10, n);
    rd_reg(REG_RESULT_ADDR, d);
    `CHK(dma_n, m + 1)
    `CHK(d, {16'h0000, res})
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_soft();
    t_ext(1'b0);
    t_ext(1'b1);
    t_wd();
    t_res();
    t_ovs(1, 2, 12'hfff, 16'h0fff);
    t_ovs(0, 3, 12'h007, 16'h0002);
    t_ovs(4, 0, 12'hfff, 16'hffe0);
    t_ovs(7, 8, 12'hfff, 16'h0fff);
    final_report();
  end
endmodule
bind conv_ctl conv_ctl_chk chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .sample_start(sample_start), .conv_done(conv_done),
  .resolution_out(resolution_out), .temperature_on(temperature_on),
  .reference_on(reference_on), .battery_on(battery_on), .dma_request(dma_request));
